// [uart_rx_defs.svh]
// offsets, field positions, reset values and timing counts of the serial receive block
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH

// register offsets on the plain register port
`define ADDR_STATUS 3'h0
`define ADDR_CTRL_A 3'h1
`define ADDR_CTRL_B 3'h2
`define ADDR_CTRL_C 3'h3
`define ADDR_DATA 3'h4
`define ADDR_BAUD 3'h5

// serial_status_reg bit positions
`define ST_PARITY_ERR 0
`define ST_NOISE 1
`define ST_FRAMING_ERR 2
`define ST_OVERRUN 3
`define ST_RX_IDLE 4
`define ST_RX_AVAIL 5
`define ST_TX_IDLE 6
`define ST_TX_EMPTY 7

// serial_control_a bit positions
`define CA_RX8 0
`define CA_TWO_STOP 3
`define CA_PARITY_ODD 4
`define CA_PARITY_EN 5
`define CA_NINE_BIT 6
`define CA_PORT_EN 7

// serial_control_b bit positions
`define CB_TX_EMPTY_IE 1
`define CB_TX_IDLE_IE 2
`define CB_RX_IE 3
`define CB_WAKE_EN 4
`define CB_ADDR_DET 5
`define CB_RX_EN 6

// reset values
`define CTRL_RESET 8'h00
`define BAUD_RESET 8'h00

// oversampling: sixteen ticks per bit, three mid-bit samples
`define OS_S0 4'h7
`define OS_S2 4'h9
`define OS_LAST 4'hF

// receive word entry layout
`define ENT_WIDTH 11
`define ENT_PE 9
`define ENT_FE 10

// wake-up settling delay
`define CLK_PERIOD_NS 10
`define WAKE_SETTLE_NS 10000
`define WAKE_SETTLE_CYCLES ((`WAKE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [uart_rx_pkg.sv]
// types shared by the serial receive block
package uart_rx_pkg;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP1 = 3'b100,
    RX_STOP2 = 3'b101,
    RX_BREAK_WAIT = 3'b110
  } rx_state_type;
endpackage

// [rx_word_fifo.sv]
// small flip-flop FIFO for received words
`timescale 1ns/100ps
module rx_word_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
    $error("fifo width and depth must be at least one");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + PW'(1);
  endfunction

  assign o_in_ready = (count != (PW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= next_ptr(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= next_ptr(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + (PW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (PW+1)'(1);
      end
    end
  end
endmodule

// [uart_rx_error_irq_wake.sv]
// serial port receive errors, interrupt pulse, address detect and pin wake-up
//
// Summary of operation
// - zero at stop bit sets framing error
// - two stops: both must be high
// - errors stored with word; reset clears
// - wrong parity sets parity error when enabled
// - interrupt signalled as low-going pulse
// - six interrupt sources, four with flags
// - own tx enables, shared receive enable
// - address detect: interrupt only if top bit
// - no address detect: interrupt every word
// - status flags read only to software
// - clock off: pin falling edge wakes
// - wake without global/port enable: no interrupt
// - after wake ignore data, delay interrupt
// - clock off pauses transfer, then resumes
// - sleep keeps all registers unchanged
// - status then data read clears flags
// - two-word buffer plus word shifting in
`timescale 1ns/100ps
`include "uart_rx_defs.svh"
module uart_rx_error_irq_wake #(
  parameter int SETTLE_CYCLES = `WAKE_SETTLE_CYCLES,
  parameter int FIFO_DEPTH = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // serial pin and system state
  input wire logic i_rx_pin,
  input wire logic i_port_clock_on,
  input wire logic i_global_irq_enable,
  input wire logic i_port_irq_enable,
  input wire logic i_tx_empty,
  input wire logic i_tx_idle,
  // requests to the processor
  output logic o_irq_n,
  output logic o_wakeup
);
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535 || FIFO_DEPTH < 1) begin : g_bad_param
    $error("settle count must be 1..65535 and fifo depth at least one");
  end

  logic [7:0] serial_control_a;
  logic [7:0] serial_control_b;
  logic [7:0] serial_control_c;
  logic [7:0] baud_divider_reg;
  logic pin_meta;
  logic pin_sync;
  logic pin_last;
  uart_rx_pkg::rx_state_type state;
  logic [7:0] baud_cnt;
  logic [3:0] os_cnt;
  logic [2:0] samples;
  logic [3:0] bit_idx;
  logic [8:0] shreg;
  logic frame_noise;
  logic par_err_acc;
  logic frame_err_acc;
  logic done;
  logic [`ENT_WIDTH-1:0] word_reg;
  logic word_noise;
  logic in_ready;
  logic out_valid;
  logic [`ENT_WIDTH-1:0] head;
  logic overrun_flag;
  logic noise_flag;
  logic status_seen;
  logic settling;
  logic [15:0] settle_cnt;
  logic wake_pending;
  logic tx_level_d;
  logic port_enable_bit;
  logic receiver_enable_bit;
  logic parity_enable_bit;
  logic nine_bit_word_select;
  logic address_detect_enable;
  logic receive_irq_enable;
  logic rx_run;
  logic tick;
  logic bit_done;
  logic bit_val;
  logic push;
  logic overrun_set;
  logic noise_set;
  logic data_rd;
  logic seq_clear;
  logic wake_arm;
  logic pin_fall;
  logic wake_start;
  logic irq_gate;
  logic tx_level;
  logic rx_event;
  logic wake_event;
  logic word_top;

  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  assign port_enable_bit = serial_control_a[`CA_PORT_EN];
  assign nine_bit_word_select = serial_control_a[`CA_NINE_BIT];
  assign parity_enable_bit = serial_control_a[`CA_PARITY_EN];
  assign receiver_enable_bit = serial_control_b[`CB_RX_EN];
  assign address_detect_enable = serial_control_b[`CB_ADDR_DET];
  assign receive_irq_enable = serial_control_b[`CB_RX_IE];

  // control registers only change on software writes; sleep leaves them alone
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      serial_control_a <= `CTRL_RESET;
      serial_control_b <= `CTRL_RESET;
      serial_control_c <= `CTRL_RESET;
      baud_divider_reg <= `BAUD_RESET;
    end else if (i_wr) begin
      if (i_addr == `ADDR_CTRL_A) begin
        serial_control_a <= {i_wdata[7:1], 1'b0};
      end else if (i_addr == `ADDR_CTRL_B) begin
        serial_control_b <= i_wdata;
      end else if (i_addr == `ADDR_CTRL_C) begin
        serial_control_c <= i_wdata;
      end else if (i_addr == `ADDR_BAUD) begin
        baud_divider_reg <= i_wdata;
      end
    end
  end

  // pin synchroniser; first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_last <= 1'b1;
    end else begin
      pin_meta <= i_rx_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // the receiver only steps while the port clock runs and no wake settle is pending
  assign rx_run = i_port_clock_on && !settling;
  assign tick = rx_run && (baud_cnt == baud_divider_reg);
  assign bit_done = tick && (os_cnt == `OS_LAST);
  assign bit_val = maj3(samples);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      baud_cnt <= 8'h00;
    end else if (state == uart_rx_pkg::RX_IDLE || tick) begin
      baud_cnt <= 8'h00;
    end else if (rx_run) begin
      baud_cnt <= baud_cnt + 8'h01;
    end
  end

  // frame state machine; holds its place when the port clock stops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= uart_rx_pkg::RX_IDLE;
      os_cnt <= 4'h0;
      samples <= 3'h7;
      bit_idx <= 4'h0;
      shreg <= 9'h000;
      frame_noise <= 1'b0;
      par_err_acc <= 1'b0;
      frame_err_acc <= 1'b0;
      done <= 1'b0;
      word_reg <= '0;
      word_noise <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!port_enable_bit || !receiver_enable_bit || settling) begin
        state <= uart_rx_pkg::RX_IDLE;
      end else if (rx_run) begin
        case (state)
          uart_rx_pkg::RX_IDLE: begin
            if (!pin_sync) begin
              state <= uart_rx_pkg::RX_START;
              os_cnt <= 4'h0;
              bit_idx <= 4'h0;
              shreg <= 9'h000;
              frame_noise <= 1'b0;
              par_err_acc <= 1'b0;
              frame_err_acc <= 1'b0;
            end
          end
          uart_rx_pkg::RX_BREAK_WAIT: begin
            if (pin_sync) begin
              state <= uart_rx_pkg::RX_IDLE;
            end
          end
          default: begin
            if (tick) begin
              os_cnt <= os_cnt + 4'h1;
              if (os_cnt >= `OS_S0 && os_cnt <= `OS_S2) begin
                samples <= {samples[1:0], pin_sync};
              end
            end
            if (bit_done) begin
              if (samples != 3'h0 && samples != 3'h7) begin
                frame_noise <= 1'b1;
              end
              case (state)
                uart_rx_pkg::RX_START: begin
                  state <= bit_val ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
                end
                uart_rx_pkg::RX_DATA: begin
                  shreg[bit_idx] <= bit_val;
                  bit_idx <= bit_idx + 4'h1;
                  if (bit_idx == (nine_bit_word_select ? 4'h8 : 4'h7)) begin
                    state <= parity_enable_bit ? uart_rx_pkg::RX_PARITY
                                               : uart_rx_pkg::RX_STOP1;
                  end
                end
                uart_rx_pkg::RX_PARITY: begin
                  // check only while parity is enabled; odd or even by control bit
                  par_err_acc <= ((^shreg) ^ bit_val) != serial_control_a[`CA_PARITY_ODD];
                  state <= uart_rx_pkg::RX_STOP1;
                end
                default: begin
                  // a low stop bit, first or second, is a framing error
                  if (!bit_val) begin
                    frame_err_acc <= 1'b1;
                  end
                  if (state == uart_rx_pkg::RX_STOP1 && serial_control_a[`CA_TWO_STOP]) begin
                    state <= uart_rx_pkg::RX_STOP2;
                  end else begin
                    done <= 1'b1;
                    word_reg <= {frame_err_acc | !bit_val, par_err_acc, shreg};
                    word_noise <= frame_noise || (samples != 3'h0 && samples != 3'h7);
                    // a break must see the line high again before a new start
                    state <= (!bit_val || frame_err_acc) ? uart_rx_pkg::RX_BREAK_WAIT
                                                         : uart_rx_pkg::RX_IDLE;
                  end
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  // two words held while a third shifts
  assign push = done && in_ready;
  assign overrun_set = done && !in_ready;
  assign noise_set = push && word_noise;
  assign data_rd = i_rd && (i_addr == `ADDR_DATA);
  assign seq_clear = data_rd && status_seen;

  rx_word_fifo #(
    .WIDTH(`ENT_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(done),
    .o_in_ready(in_ready),
    .i_in_data(word_reg),
    .o_out_valid(out_valid),
    .i_out_ready(data_rd),
    .o_out_data(head)
  );

  // flags change only by hardware; status then data read clears them, a new set wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      overrun_flag <= 1'b0;
      noise_flag <= 1'b0;
      status_seen <= 1'b0;
    end else begin
      if (overrun_set) begin
        overrun_flag <= 1'b1;
      end else if (seq_clear) begin
        overrun_flag <= 1'b0;
      end
      if (noise_set) begin
        noise_flag <= 1'b1;
      end else if (seq_clear) begin
        noise_flag <= 1'b0;
      end
      if (i_rd && i_addr == `ADDR_STATUS) begin
        status_seen <= 1'b1;
      end else if (data_rd) begin
        status_seen <= 1'b0;
      end
    end
  end

  // read port; unmapped offsets read zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (i_addr == `ADDR_STATUS) begin
        o_rdata <= {i_tx_empty, i_tx_idle, out_valid, state == uart_rx_pkg::RX_IDLE,
                    overrun_flag, head[`ENT_FE] & out_valid, noise_flag,
                    head[`ENT_PE] & out_valid};
      end else if (i_addr == `ADDR_CTRL_A) begin
        o_rdata <= {serial_control_a[7:1], head[8] & out_valid};
      end else if (i_addr == `ADDR_CTRL_B) begin
        o_rdata <= serial_control_b;
      end else if (i_addr == `ADDR_CTRL_C) begin
        o_rdata <= serial_control_c;
      end else if (i_addr == `ADDR_DATA) begin
        o_rdata <= out_valid ? head[7:0] : 8'h00;
      end else if (i_addr == `ADDR_BAUD) begin
        o_rdata <= baud_divider_reg;
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // wake-up: armed only with the port clock stopped
  assign wake_arm = !i_port_clock_on && serial_control_b[`CB_WAKE_EN] && port_enable_bit
                    && receiver_enable_bit && receive_irq_enable;
  assign pin_fall = pin_last && !pin_sync;
  assign wake_start = wake_arm && pin_fall && !settling;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wakeup <= 1'b0;
      settling <= 1'b0;
      settle_cnt <= 16'h0000;
      wake_pending <= 1'b0;
    end else begin
      o_wakeup <= wake_start;
      if (wake_start) begin
        settling <= 1'b1;
        settle_cnt <= 16'(SETTLE_CYCLES - 1);
        wake_pending <= 1'b1;
      end else if (settling) begin
        // data and interrupt held back until the clock has settled
        if (settle_cnt == 16'h0000) begin
          settling <= 1'b0;
        end else begin
          settle_cnt <= settle_cnt - 16'h0001;
        end
      end else begin
        wake_pending <= 1'b0;
      end
    end
  end

  // interrupt sources: two tx levels, rx word, overrun, address detect, wake
  assign irq_gate = i_global_irq_enable && i_port_irq_enable;
  assign tx_level = (i_tx_empty && serial_control_b[`CB_TX_EMPTY_IE])
                    || (i_tx_idle && serial_control_b[`CB_TX_IDLE_IE]);
  assign word_top = nine_bit_word_select ? word_reg[8] : word_reg[7];
  // address detect qualifies the data-available request by the top bit
  assign rx_event = receive_irq_enable && ((push && (!address_detect_enable || word_top))
                    || overrun_set);
  assign wake_event = wake_pending && !settling;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_level_d <= 1'b0;
      o_irq_n <= 1'b1;
    end else begin
      tx_level_d <= tx_level;
      // one-cycle low pulse per new condition
      o_irq_n <= !(irq_gate && ((tx_level && !tx_level_d) || rx_event || wake_event));
    end
  end

  sequence seq_wake_start;
    wake_arm && pin_fall && !settling;
  endsequence

  sequence seq_status_then_data;
    status_seen && data_rd && !noise_set && !overrun_set;
  endsequence

  a_wake_pulse_out: assert property (@(posedge i_clk) disable iff (i_rst)
    seq_wake_start |=> o_wakeup && settling)
    else $error("wake edge did not raise wakeup");
  a_wake_irq_held: assert property (@(posedge i_clk) disable iff (i_rst)
    (settling && wake_pending && !rx_event && !(tx_level && !tx_level_d)) |=> o_irq_n)
    else $error("wake interrupt before settle end");
  a_settle_ignores_pin: assert property (@(posedge i_clk) disable iff (i_rst)
    settling |=> state == uart_rx_pkg::RX_IDLE && !done)
    else $error("receiver ran while settling");
  a_irq_gated_low: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_irq_n |-> $past(irq_gate))
    else $error("interrupt pulse without global and port enable");
  a_irq_one_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
    (irq_gate && receive_irq_enable && overrun_set) |=> !o_irq_n)
    else $error("overrun did not pulse interrupt low");
  a_addr_detect_low: assert property (@(posedge i_clk) disable iff (i_rst)
    (push && address_detect_enable && !word_top && !overrun_set && !wake_event
     && !(tx_level && !tx_level_d)) |=> o_irq_n)
    else $error("address detect passed a data word");
  a_stop_low_framing: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_run && port_enable_bit && receiver_enable_bit && bit_done && !bit_val
     && (state == uart_rx_pkg::RX_STOP1 || state == uart_rx_pkg::RX_STOP2))
    |=> frame_err_acc || word_reg[`ENT_FE])
    else $error("low stop bit not flagged");
  a_overrun_sets: assert property (@(posedge i_clk) disable iff (i_rst)
    overrun_set |=> overrun_flag && out_valid)
    else $error("full buffer did not flag overrun");
  a_flags_clear_seq: assert property (@(posedge i_clk) disable iff (i_rst)
    seq_status_then_data |=> !noise_flag && !overrun_flag)
    else $error("status then data read left flags set");
  a_pause_holds: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_port_clock_on && port_enable_bit && receiver_enable_bit && !wake_start
     && !settling && !i_wr) |=> $stable(os_cnt) && $stable(state))
    else $error("receiver moved with port clock off");
  a_sleep_keeps_regs: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_port_clock_on && !i_wr) |=> $stable(serial_control_b) && $stable(baud_divider_reg))
    else $error("register changed while asleep");
endmodule

// [uart_tx_model.sv]
// remote serial transmitter model that drives the receive pin
`timescale 1ns/100ps
module uart_tx_model #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input wire logic i_clk,
  // serial line
  output logic o_line
);
  // line idles high between frames
  initial o_line = 1'b1;

  // bit length and glitched data bit may be changed by the bench between frames
  int bit_clks = BIT_CLKS;
  int glitch_at = -1;

  task automatic hold_bit(input logic level);
    o_line <= level;
    repeat (bit_clks) @(posedge i_clk);
  endtask

  // one-cycle inversion in mid-bit, caught by only one of the three samples
  task automatic hold_glitch(input logic level);
    o_line <= level;
    repeat (9) @(posedge i_clk);
    o_line <= ~level;
    @(posedge i_clk);
    o_line <= level;
    repeat (bit_clks - 10) @(posedge i_clk);
  endtask

  // stop levels are passed in so that broken frames can be forced
  task automatic send(input logic [8:0] word, input int nbits, input logic par_en,
                      input logic par_bit, input int nstop, input logic [1:0] stops);
    @(posedge i_clk);
    hold_bit(1'b0);
    for (int i = 0; i < nbits; i++) begin
      if (i == glitch_at) begin
        hold_glitch(word[i]);
      end else begin
        hold_bit(word[i]);
      end
    end
    if (par_en) begin
      hold_bit(par_bit);
    end
    hold_bit(stops[0]);
    if (nstop == 2) begin
      hold_bit(stops[1]);
    end
    o_line <= 1'b1;
  endtask

  // a lone falling edge, used to wake the port while its clock is off
  task automatic fall();
    @(posedge i_clk);
    hold_bit(1'b0);
    o_line <= 1'b1;
  endtask
endmodule

// [uart_rx_error_irq_wake_tb.sv]
// self-checking bench for the serial receive error, interrupt and wake block
`timescale 1ns/100ps
`include "uart_rx_defs.svh"
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module uart_rx_error_irq_wake_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_port_clock_on = 1'b1;
  logic i_global_irq_enable = 1'b1;
  logic i_port_irq_enable = 1'b1;
  logic i_tx_empty = 1'b0;
  logic i_tx_idle = 1'b0;
  logic [7:0] o_rdata;
  logic rx_line;
  logic o_irq_n;
  logic o_wakeup;
  logic [7:0] rd_val;
  int errors = 0;
  int cmp_count = 0;
  int irq_cnt = 0;
  int wake_cnt = 0;
  int cycles = 0;

  always #5 i_clk = ~i_clk;

  // short settle keeps the wake tests brief
  uart_rx_error_irq_wake #(.SETTLE_CYCLES(4), .FIFO_DEPTH(2)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_pin(rx_line), .i_port_clock_on(i_port_clock_on),
    .i_global_irq_enable(i_global_irq_enable), .i_port_irq_enable(i_port_irq_enable),
    .i_tx_empty(i_tx_empty), .i_tx_idle(i_tx_idle), .o_irq_n(o_irq_n), .o_wakeup(o_wakeup));

  uart_tx_model #(.BIT_CLKS(16)) remote (.i_clk(i_clk), .o_line(rx_line));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // pulse counters and hang guard
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (o_irq_n === 1'b0) irq_cnt <= irq_cnt + 1;
    if (o_wakeup === 1'b1) wake_cnt <= wake_cnt + 1;
    if (cycles == 20000) begin
      errors++;
      $display("[FAIL] %0t run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [2:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    rd_val = o_rdata;
  endtask

  task automatic chk_reg(input logic [2:0] a, input logic [7:0] mask, input logic [7:0] exp);
    rd(a);
    `CHECK(rd_val & mask, exp)
  endtask

  // margin covers pin sync, push and the registered pulse
  task automatic frame(input logic [8:0] w, input int nbits, input logic par_en,
                       input logic par_bit, input int nstop, input logic [1:0] stops);
    remote.send(w, nbits, par_en, par_bit, nstop, stops);
    repeat (8) @(posedge i_clk);
  endtask

  task automatic chk_irq(input int base, input int n);
    `CHECK(irq_cnt - base, n)
  endtask

  initial begin
    int base;
    int wbase;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    chk_reg(`ADDR_CTRL_A, 8'hFF, `CTRL_RESET);
    chk_reg(`ADDR_BAUD, 8'hFF, `BAUD_RESET);
    chk_reg(`ADDR_STATUS, 8'h2D, 8'h00);
    wr(`ADDR_CTRL_A, 8'h80);
    wr(`ADDR_CTRL_B, 8'h48);
    base = irq_cnt;
    frame(9'h0A5, 8, 1'b0, 1'b0, 1, 2'b11);
    chk_irq(base, 1);
    chk_reg(`ADDR_STATUS, 8'h2D, 8'h20);
    chk_reg(`ADDR_DATA, 8'hFF, 8'hA5);
    chk_reg(`ADDR_STATUS, 8'h2D, 8'h00);
    wr(`ADDR_STATUS, 8'hFF);
    chk_reg(`ADDR_STATUS, 8'h2D, 8'h00);
    frame(9'h03C, 8, 1'b0, 1'b0, 1, 2'b00);
    chk_reg(`ADDR_STATUS, 8'h2D, 8'h24);
    chk_reg(`ADDR_DATA, 8'hFF, 8'h3C);
    // second stop low, then a clean two-stop frame
    wr(`ADDR_CTRL_A, 8'h88);
    frame(9'h011, 8, 1'b0, 1'b0, 2, 2'b01);
    chk_reg(`ADDR_STATUS, 8'h2D, 8'h24);
    // reset in mid-run drops the flagged word and its error flags
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    chk_reg(`ADDR_STATUS, 8'h2D, 8'h00);
    wr(`ADDR_CTRL_A, 8'h88);
    wr(`ADDR_CTRL_B, 8'h48);
    frame(9'h012, 8, 1'b0, 1'b0, 2, 2'b11);
    chk_reg(`ADDR_STATUS, 8'h2D, 8'h20);
    rd(`ADDR_DATA);
    // even and odd parity, each with a right and a wrong parity bit
    for (int k = 0; k < 4; k++) begin
      wr(`ADDR_CTRL_A, k[1] ? 8'hB0 : 8'hA0);
      frame(9'h013, 8, 1'b1, (^8'h13) ^ k[1] ^ k[0], 1, 2'b11);
      chk_reg(`ADDR_STATUS, 8'h2D, k[0] ? 8'h21 : 8'h20);
      rd(`ADDR_DATA);
    end
    // address detect in eight and nine bit words; parity kept off
    wr(`ADDR_CTRL_B, 8'h68);
    for (int k = 0; k < 2; k++) begin
      wr(`ADDR_CTRL_A, k ? 8'hC0 : 8'h80);
      base = irq_cnt;
      frame(k ? 9'h080 : 9'h005, 8 + k, 1'b0, 1'b0, 1, 2'b11);
      chk_irq(base, 0);
      frame(k ? 9'h100 : 9'h085, 8 + k, 1'b0, 1'b0, 1, 2'b11);
      chk_irq(base, 1);
      rd(`ADDR_STATUS);
      rd(`ADDR_DATA);
      rd(`ADDR_DATA);
    end
    // third word with two held: dropped, overrun flagged and signalled
    wr(`ADDR_CTRL_A, 8'h80);
    wr(`ADDR_CTRL_B, 8'h48);
    base = irq_cnt;
    frame(9'h011, 8, 1'b0, 1'b0, 1, 2'b11);
    frame(9'h022, 8, 1'b0, 1'b0, 1, 2'b11);
    frame(9'h033, 8, 1'b0, 1'b0, 1, 2'b11);
    chk_irq(base, 3);
    chk_reg(`ADDR_STATUS, 8'h2D, 8'h28);
    chk_reg(`ADDR_DATA, 8'hFF, 8'h11);
    chk_reg(`ADDR_DATA, 8'hFF, 8'h22);
    chk_reg(`ADDR_STATUS, 8'h2D, 8'h00);
    // a glitch inside one data bit flags noise; status then data clears it
    remote.glitch_at = 3;
    frame(9'h055, 8, 1'b0, 1'b0, 1, 2'b11);
    remote.glitch_at = -1;
    chk_reg(`ADDR_STATUS, 8'h2F, 8'h22);
    chk_reg(`ADDR_DATA, 8'hFF, 8'h55);
    chk_reg(`ADDR_STATUS, 8'h2F, 8'h00);
    // slower bit time through the baud divider
    wr(`ADDR_BAUD, 8'h01);
    remote.bit_clks = 32;
    frame(9'h05A, 8, 1'b0, 1'b0, 1, 2'b11);
    chk_reg(`ADDR_DATA, 8'hFF, 8'h5A);
    chk_reg(`ADDR_BAUD, 8'hFF, 8'h01);
    wr(`ADDR_BAUD, 8'h00);
    remote.bit_clks = 16;
    // transmit sources, each behind its own enable
    wr(`ADDR_CTRL_B, 8'h02);
    base = irq_cnt;
    i_tx_empty <= 1'b1;
    @(posedge i_clk);
    i_tx_idle <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk_irq(base, 1);
    chk_reg(`ADDR_STATUS, 8'hC0, 8'hC0);
    i_tx_empty <= 1'b0;
    i_tx_idle <= 1'b0;
    wr(`ADDR_CTRL_B, 8'h04);
    i_tx_idle <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk_irq(base, 2);
    // pin wake with the port clock off, with and without the global enable
    wr(`ADDR_CTRL_B, 8'h58);
    i_port_clock_on <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      i_global_irq_enable <= (k == 0);
      base = irq_cnt;
      wbase = wake_cnt;
      remote.fall();
      repeat (8) @(posedge i_clk);
      `CHECK(wake_cnt - wbase, 1)
      chk_irq(base, k ? 0 : 1);
    end
    i_port_clock_on <= 1'b1;
    i_global_irq_enable <= 1'b1;
    chk_reg(`ADDR_CTRL_B, 8'hFF, 8'h58);
    chk_reg(`ADDR_CTRL_A, 8'hFE, 8'h80);
    report_and_stop();
  end
endmodule
